/* File: uswin_pkg.sv */
// constants and types for the shadow rx/tx window uart block
// assumes a single 125 MHz clock and a one-slave ahb-lite bus
package uswin_pkg;

    // ==========================================
    // clock and line timing
    localparam int unsigned CLK_HZ = 125_000_000;
    localparam int unsigned BAUD = 115_200;
    localparam int unsigned BIT_CYC_I = CLK_HZ / BAUD;
    localparam logic [10:0] BIT_LAST = 11'(BIT_CYC_I - 1);
    localparam logic [10:0] HALF_LAST = 11'(BIT_CYC_I / 2 - 1);
    // infrared pulse is three sixteenths of a bit
    localparam logic [10:0] IR_CYC = 11'(BIT_CYC_I * 3 / 16);
    localparam logic [2:0] LAST_BIT = 3'h7;

    // ==========================================
    // character storage
    localparam int DW = 8;
    localparam int DEPTH = 16;
    localparam logic [4:0] DEPTH_C = 5'h10;

    // ==========================================
    // register map, byte addresses
    localparam logic [31:0] SHADOW9_ADDR = 32'h5000_1154;
    localparam logic [31:0] SHADOW10_ADDR = 32'h5000_1158;
    localparam logic [31:0] SHADOW_STRIDE = 32'h0000_0004;
    localparam logic [31:0] SHADOW9_IDX = 32'h0000_0009;
    localparam logic [31:0] SHADOW_BASE =
        SHADOW9_ADDR - SHADOW9_IDX * SHADOW_STRIDE;
    localparam logic [31:0] SHADOW_SPAN = 32'h0000_0040;
    localparam logic [31:0] CTRL_ADDR = 32'h5000_1180;
    localparam logic [31:0] LSTAT_ADDR = 32'h5000_1184;
    localparam logic [31:0] ISTAT_ADDR = 32'h5000_1188;
    localparam logic [31:0] IMASK_ADDR = 32'h5000_118C;

    // ==========================================
    // field positions
    localparam int CTRL_FIFO_EN = 0;
    localparam int CTRL_IR_MODE = 1;
    localparam int LS_DR = 0;
    localparam int LS_OE = 1;
    localparam int LS_FE = 3;
    localparam int LS_TX_HOLDING_EMPTY_FLAG = 5;
    localparam int INT_RX = 0;
    localparam int INT_OE = 1;
    localparam int INT_TX_HOLDING_EMPTY_FLAG = 2;
    localparam int INT_TXLOST = 3;
    localparam int INT_W = 4;

    // ==========================================
    // serial state machines, gray along the path
    typedef enum logic [1:0] {
        USW_IDLE = 2'h0,
        USW_START = 2'h1,
        USW_DATA = 2'h3,
        USW_STOP = 2'h2
    } uswin_ser_t;

endpackage

/* File: uswin_if.sv */
// carriers between the window core, its fifos and its bus front end
// assumes all parties run on the same clock
`timescale 1ns/1ps

// ==========================================
// character fifo port
interface uswin_fifo_if;
    logic push;
    logic clr;
    logic pop;
    logic [7:0] din;
    logic [7:0] head;
    logic full;
    logic empty;
    modport store(input push, clr, pop, din, output head, full, empty);
    modport user(output push, clr, pop, din, input head, full, empty);
endinterface

// ==========================================
// register access strobe from the bus front end
interface uswin_bus_if;
    logic acc;
    logic wr;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    modport slave(output acc, wr, addr, wdata, input rdata);
    modport core(input acc, wr, addr, wdata, output rdata);
endinterface

/* File: uswin_fifo.sv */
// flip-flop character fifo with flush and overwrite support
// assumes the user never pops when empty
`timescale 1ns/1ps

module uswin_fifo
    import uswin_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // fifo port
    uswin_fifo_if.store f
);

    typedef struct packed {
        logic [DEPTH-1:0][DW-1:0] mem;
        logic [3:0] rp;
        logic [3:0] wp;
        logic [4:0] cnt;
    } uswin_fifo_t;

    uswin_fifo_t s;
    uswin_fifo_t next_s;

    assign f.head = s.mem[s.rp];
    assign f.full = (s.cnt == DEPTH_C);
    assign f.empty = (s.cnt == 5'h00);

    // ==========================================
    // next state
    always_comb begin
        next_s = s;
        if (f.clr) begin
            next_s.rp = 4'h0;
            next_s.wp = 4'h0;
            next_s.cnt = 5'h00;
        end else if (f.pop && !f.empty) begin
            next_s.rp = s.rp + 4'h1;
            next_s.cnt = s.cnt - 5'h01;
        end
        // a push into a full fifo is dropped unless a pop or a clear frees a slot
        if (f.push && (f.clr || !f.full || f.pop)) begin
            next_s.mem[next_s.wp] = f.din;
            next_s.wp = next_s.wp + 4'h1;
            next_s.cnt = next_s.cnt + 5'h01;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

endmodule

/* File: uswin_ahb.sv */
// ahb-lite slave front end: one wait state on every transfer
// assumes it is the only slave, so hready equals its hreadyout
`timescale 1ns/1ps

module uswin_ahb
    import uswin_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // core access
    uswin_bus_if.slave b
);

    typedef struct packed {
        logic pend;
        logic wr;
        logic [31:0] addr;
        logic [31:0] rdata;
        logic ready;
        logic resp;
    } uswin_ahb_t;

    uswin_ahb_t s;
    uswin_ahb_t next_s;

    assign b.acc = s.pend;
    assign b.wr = s.wr;
    assign b.addr = s.addr;
    assign b.wdata = hwdata;
    assign hrdata = s.rdata;
    assign hreadyout = s.ready;
    // every answer is okay, so the flop holds its reset zero
    assign hresp = s.resp;

    // ==========================================
    // next state
    always_comb begin
        next_s = s;
        if (s.pend) begin
            // the wait state lets read data come from a flop
            next_s.pend = 1'b0;
            next_s.rdata = b.rdata;
            next_s.ready = 1'b1;
        end else if (hsel && htrans[1] && hready) begin
            next_s.pend = 1'b1;
            next_s.wr = hwrite;
            next_s.addr = haddr;
            next_s.ready = 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '{pend: 1'b0, wr: 1'b0, addr: 32'h0, rdata: 32'h0,
                   ready: 1'b1, resp: 1'b0};
        end else begin
            s <= next_s;
        end
    end

endmodule

/* File: uswin_top.sv */
// shadow rx/tx data window of a uart, with 8n1 serial engines
// assumes serial inputs are synchronous to hclk
`timescale 1ns/1ps

module uswin_top
    import uswin_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // serial and infrared line
    input wire logic sin,
    input wire logic sir_in,
    output logic sout,
    output logic sir_out_n,
    // interrupt
    output logic irq
);

    typedef struct packed {
        logic fifo_en;
        logic ir_mode;
        logic oe;
        logic fe;
        logic [INT_W-1:0] ists;
        logic [INT_W-1:0] imask;
        logic tx_holding_empty_flag_q;
        uswin_ser_t txs;
        logic [10:0] txc;
        logic [2:0] txb;
        logic [7:0] txsh;
        uswin_ser_t rxs;
        logic [10:0] rxc;
        logic [2:0] rxb;
        logic [7:0] rxsh;
        logic sout;
        logic sir_n;
        logic irq;
    } uswin_core_t;

    uswin_core_t s;
    uswin_core_t next_s;

    uswin_fifo_if rxf();
    uswin_fifo_if txf();
    uswin_bus_if bus();

    logic rd;
    logic wr;
    logic shadow;
    logic [31:0] offs;
    logic rx_bit;
    logic line;
    logic rx_done;
    logic flush;
    logic [INT_W-1:0] iset;
    logic [INT_W-1:0] iclr;

    // ==========================================
    // submodules
    uswin_ahb u_ahb (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hready(hready),
        .hwdata(hwdata),
        .hrdata(hrdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .b(bus.slave)
    );

    uswin_fifo u_rxf (
        .hclk(hclk),
        .hresetn(hresetn),
        .f(rxf.store)
    );

    uswin_fifo u_txf (
        .hclk(hclk),
        .hresetn(hresetn),
        .f(txf.store)
    );

    assign sout = s.sout;
    assign sir_out_n = s.sir_n;
    assign irq = s.irq;

    // ==========================================
    // next state
    always_comb begin
        next_s = s;
        rd = bus.acc && !bus.wr;
        wr = bus.acc && bus.wr;
        offs = bus.addr - SHADOW_BASE;
        shadow = (offs < SHADOW_SPAN) && (offs[1:0] == 2'h0);
        rx_bit = s.ir_mode ? !sir_in : sin;
        rx_done = 1'b0;
        iset = '0;
        iclr = '0;
        flush = 1'b0;
        line = 1'b1;
        bus.rdata = 32'h0;
        rxf.pop = 1'b0;
        rxf.push = 1'b0;
        rxf.clr = 1'b0;
        rxf.din = s.rxsh;
        txf.pop = 1'b0;
        txf.push = 1'b0;
        txf.clr = 1'b0;
        txf.din = bus.wdata[7:0];

        // register reads; hsize is ignored, whole words only
        if (shadow) begin
            bus.rdata = {24'h0, rxf.head};
        end else begin
            case (bus.addr)
                CTRL_ADDR: begin
                    bus.rdata[CTRL_FIFO_EN] = s.fifo_en;
                    bus.rdata[CTRL_IR_MODE] = s.ir_mode;
                end
                LSTAT_ADDR: begin
                    bus.rdata[LS_DR] = !rxf.empty;
                    bus.rdata[LS_OE] = s.oe;
                    bus.rdata[LS_FE] = s.fe;
                    bus.rdata[LS_TX_HOLDING_EMPTY_FLAG] = txf.empty;
                end
                ISTAT_ADDR: begin
                    bus.rdata[INT_W-1:0] = s.ists;
                end
                IMASK_ADDR: begin
                    bus.rdata[INT_W-1:0] = s.imask;
                end
                default: begin
                    bus.rdata = 32'h0;
                end
            endcase
        end

        if (rd && shadow && !rxf.empty) begin
            rxf.pop = 1'b1;
        end
        // line status errors clear on read
        if (rd && bus.addr == LSTAT_ADDR) begin
            next_s.oe = 1'b0;
            next_s.fe = 1'b0;
        end

        // register writes
        if (wr && shadow) begin
            txf.push = 1'b1;
            txf.clr = !s.fifo_en;
        end else if (wr) begin
            case (bus.addr)
                CTRL_ADDR: begin
                    next_s.fifo_en = bus.wdata[CTRL_FIFO_EN];
                    next_s.ir_mode = bus.wdata[CTRL_IR_MODE];
                    // switching fifo mode discards stored characters
                    flush = bus.wdata[CTRL_FIFO_EN] != s.fifo_en;
                end
                ISTAT_ADDR: begin
                    iclr = bus.wdata[INT_W-1:0];
                end
                IMASK_ADDR: begin
                    next_s.imask = bus.wdata[INT_W-1:0];
                end
                default: begin
                    next_s.imask = s.imask;
                end
            endcase
        end

        // ==========================================
        // receiver, 8n1 sampled at mid bit
        case (s.rxs)
            USW_IDLE: begin
                if (!rx_bit) begin
                    next_s.rxs = USW_START;
                    next_s.rxc = 11'h0;
                end
            end
            USW_START: begin
                if (s.rxc == HALF_LAST) begin
                    next_s.rxc = 11'h0;
                    next_s.rxb = 3'h0;
                    // a short glitch is not a start bit
                    next_s.rxs = rx_bit ? USW_IDLE : USW_DATA;
                end else begin
                    next_s.rxc = s.rxc + 11'h1;
                end
            end
            USW_DATA: begin
                if (s.rxc == BIT_LAST) begin
                    next_s.rxc = 11'h0;
                    next_s.rxsh = {rx_bit, s.rxsh[7:1]};
                    next_s.rxb = s.rxb + 3'h1;
                    if (s.rxb == LAST_BIT) begin
                        next_s.rxs = USW_STOP;
                    end
                end else begin
                    next_s.rxc = s.rxc + 11'h1;
                end
            end
            USW_STOP: begin
                if (s.rxc == BIT_LAST) begin
                    next_s.rxs = USW_IDLE;
                    rx_done = 1'b1;
                    if (!rx_bit) begin
                        next_s.fe = 1'b1;
                    end
                end else begin
                    next_s.rxc = s.rxc + 11'h1;
                end
            end
            default: begin
                next_s.rxs = USW_IDLE;
            end
        endcase

        if (rx_done) begin
            rxf.push = 1'b1;
            iset[INT_RX] = 1'b1;
            rxf.clr = !s.fifo_en;
            if (!s.fifo_en && !rxf.empty && !rxf.pop) begin
                next_s.oe = 1'b1;
                iset[INT_OE] = 1'b1;
            end
            if (s.fifo_en && rxf.full && !rxf.pop) begin
                next_s.oe = 1'b1;
                iset[INT_OE] = 1'b1;
            end
        end
        if (flush) begin
            rxf.clr = 1'b1;
            txf.clr = 1'b1;
        end

        // ==========================================
        // transmitter, 8n1
        case (s.txs)
            USW_IDLE: begin
                if (!txf.empty) begin
                    txf.pop = 1'b1;
                    next_s.txsh = txf.head;
                    next_s.txs = USW_START;
                    next_s.txc = 11'h0;
                end
            end
            USW_START: begin
                if (s.txc == BIT_LAST) begin
                    next_s.txc = 11'h0;
                    next_s.txb = 3'h0;
                    next_s.txs = USW_DATA;
                end else begin
                    next_s.txc = s.txc + 11'h1;
                end
            end
            USW_DATA: begin
                if (s.txc == BIT_LAST) begin
                    next_s.txc = 11'h0;
                    next_s.txsh = {1'b1, s.txsh[7:1]};
                    next_s.txb = s.txb + 3'h1;
                    if (s.txb == LAST_BIT) begin
                        next_s.txs = USW_STOP;
                    end
                end else begin
                    next_s.txc = s.txc + 11'h1;
                end
            end
            USW_STOP: begin
                if (s.txc == BIT_LAST) begin
                    next_s.txs = USW_IDLE;
                end else begin
                    next_s.txc = s.txc + 11'h1;
                end
            end
            default: begin
                next_s.txs = USW_IDLE;
            end
        endcase

        // full fifo drops write
        // pop is known only here, so a freed slot is not a lost write
        if (wr && shadow && s.fifo_en && txf.full && !txf.pop) begin
            iset[INT_TXLOST] = 1'b1;
        end

        case (next_s.txs)
            USW_START: line = 1'b0;
            USW_DATA: line = next_s.txsh[0];
            default: line = 1'b1;
        endcase
        next_s.sout = s.ir_mode ? 1'b1 : line;
        // ir sends a short low pulse for each zero bit
        next_s.sir_n = !(s.ir_mode && !line && next_s.txc < IR_CYC);

        next_s.tx_holding_empty_flag_q = txf.empty;
        if (txf.empty && !s.tx_holding_empty_flag_q) begin
            iset[INT_TX_HOLDING_EMPTY_FLAG] = 1'b1;
        end

        // ==========================================
        // sticky status, set wins over clear
        next_s.ists = (s.ists & ~iclr) | iset;
        next_s.irq = |(next_s.ists & next_s.imask);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '{fifo_en: 1'b0, ir_mode: 1'b0, oe: 1'b0, fe: 1'b0,
                   ists: '0, imask: '0, tx_holding_empty_flag_q: 1'b1, txs: USW_IDLE,
                   txc: 11'h0, txb: 3'h0, txsh: 8'h00, rxs: USW_IDLE,
                   rxc: 11'h0, rxb: 3'h0, rxsh: 8'h00, sout: 1'b1,
                   sir_n: 1'b1, irq: 1'b0};
        end else begin
            s <= next_s;
        end
    end

endmodule

/* File: uswin_top_assertions.sv */
// concurrent checks on the ports of the shadow window uart top
// assumes one clock, hready looped back from hreadyout
`timescale 1ns/1ps

module uswin_top_assertions
    import uswin_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // serial and infrared line
    input wire logic sin,
    input wire logic sir_in,
    input wire logic sout,
    input wire logic sir_out_n,
    // interrupt
    input wire logic irq
);
    // ==========================================
    // helpers
    logic dph_wr;
    logic [10:0] ir_lo;
    logic [13:0] so_lo;
    wire acc = hsel && htrans[1] && hready;
    wire in_win = haddr >= SHADOW_BASE && haddr < SHADOW_BASE + SHADOW_SPAN;
    wire in_ctl = haddr >= CTRL_ADDR && haddr <= IMASK_ADDR;
    wire unmapped = !in_win && !in_ctl && haddr[1:0] == 2'h0;

    // run lengths of the low line levels, cleared while high
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph_wr <= 1'b0;
            ir_lo <= 11'h0;
            so_lo <= 14'h0;
        end else begin
            if (hreadyout) dph_wr <= acc && hwrite;
            ir_lo <= sir_out_n ? 11'h0 : ir_lo + 11'h1;
            so_lo <= sout ? 14'h0 : so_lo + 14'h1;
        end
    end

    // ==========================================
    // properties
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_one_wait;
        acc |=> !hreadyout ##1 hreadyout;
    endproperty
    a_one_wait: assert property (p_one_wait)
        else $error("wait state is not exactly one cycle");
    property p_okay;
        hresp == 1'b0;
    endproperty
    a_okay: assert property (p_okay)
        else $error("slave answered other than okay");
    property p_rdata_hold;
        hreadyout && $past(hreadyout) |-> $stable(hrdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("read data moved outside a transfer");
    property p_upper_zero;
        acc && !hwrite && in_win |-> ##2 hrdata[31:8] == 24'h0;
    endproperty
    a_upper_zero: assert property (p_upper_zero)
        else $error("window read has upper bits set");
    property p_unmapped;
        acc && !hwrite && unmapped |-> ##2 hrdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read is not zero");
    property p_line_excl;
        sout || sir_out_n;
    endproperty
    a_line_excl: assert property (p_line_excl)
        else $error("serial and infrared outputs active together");
    property p_ir_pulse;
        $rose(sir_out_n) |-> ir_lo == IR_CYC;
    endproperty
    a_ir_pulse: assert property (p_ir_pulse)
        else $error("infrared pulse width wrong");
    property p_sout_bits;
        $rose(sout) |-> so_lo % 14'(BIT_CYC_I) == 14'h0;
    endproperty
    a_sout_bits: assert property (p_sout_bits)
        else $error("serial low run not whole bit times");
    // irq may only drop after a register write lands
    property p_irq_clear;
        $fell(irq) |-> $past(dph_wr) || $past(dph_wr, 2);
    endproperty
    a_irq_clear: assert property (p_irq_clear)
        else $error("interrupt dropped without a write");

    c_read: cover property (acc && !hwrite && in_win ##2 hreadyout);
    c_ir: cover property ($rose(sir_out_n));
    c_irq: cover property ($rose(irq));
endmodule

bind uswin_top uswin_top_assertions chk_u (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .sin(sin), .sir_in(sir_in),
    .sout(sout), .sir_out_n(sir_out_n), .irq(irq));

/* File: uswin_peer.sv */
// remote 8n1 uart or infrared peer facing the window block
// assumes the bench sets ir only while both lines are idle
`timescale 1ns/1ps

module uswin_peer
    import uswin_pkg::*;
(
    // clock and mode
    input wire logic hclk,
    input wire logic ir,
    // lines from the block
    input wire logic sout,
    input wire logic sir_out_n,
    // lines to the block
    output logic sin,
    output logic sir_in,
    // received character
    output logic got,
    output logic [7:0] got_ch,
    output logic frame_ok
);
    logic [9:0] sh;

    initial begin
        sin = 1'b1;
        sir_in = 1'b0;
        got = 1'b0;
        got_ch = 8'h0;
        frame_ok = 1'b0;
    end

    // ==========================================
    // sender
    // serial or infrared input
    task automatic send(input logic [7:0] ch);
        logic [9:0] f;
        f = {1'b1, ch, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge hclk);
            sin <= ir | f[i];
            sir_in <= ir & !f[i];
            repeat (BIT_CYC_I - 1) @(posedge hclk);
        end
    endtask

    // ==========================================
    // receiver
    // decode serial or ir output
    // stop is sampled mid-bit for serial and 100 cycles into the bit for ir, so a back-to-back start is not missed
    always begin
        @(posedge hclk);
        got <= 1'b0;
        if ((ir ? sir_out_n : sout) === 1'b0) begin
            repeat (ir ? 100 : BIT_CYC_I / 2) @(posedge hclk);
            for (int i = 0; i < 10; i++) begin
                sh[i] = ir ? sir_out_n : sout;
                if (i < 9) repeat (BIT_CYC_I) @(posedge hclk);
            end
            got_ch <= sh[8:1];
            frame_ok <= !sh[0] && sh[9];
            got <= 1'b1;
        end
    end
endmodule

/* File: uart_shadow_rx_tx_window_tb.sv */
// self-checking bench for the shadow window uart top
// assumes the peer model and the bound checker are compiled alongside
`timescale 1ns/1ps

module uart_shadow_rx_tx_window_tb;
    import uswin_pkg::*;
    localparam int LIMIT = 80000;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, ir = 0, dph_rd = 0;
    logic [1:0] htrans = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, v;
    logic hreadyout, hresp, sin, sir_in, sout, sir_out_n, irq, got, frame_ok;
    logic [7:0] got_ch, x, y, p, q, r, t;
    logic [63:0] e_v;
    logic [63:0] rd_q[$];
    logic [7:0] tx_q[$];
    int fails = 0, check_count = 0, cyc = 0;

    always #4 hclk = ~hclk;

    uswin_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .sin(sin), .sir_in(sir_in),
        .sout(sout), .sir_out_n(sir_out_n), .irq(irq));
    uswin_peer peer_u (.hclk(hclk), .ir(ir), .sout(sout),
        .sir_out_n(sir_out_n), .sin(sin), .sir_in(sir_in), .got(got),
        .got_ch(got_ch), .frame_ok(frame_ok));

    // ==========================================
    // tasks
    task automatic check(input logic [31:0] a, input logic [31:0] e);
        check_count++;
        if (a !== e) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, a, e);
        end
    endtask

    task automatic conclude;
        $display("counts: %0d mismatches, %0d checks", fails, check_count);
        if (fails == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // single ahb-lite transfer; reads note the expected word and mask
    task automatic xfer(input logic w, input logic [31:0] a,
                        input logic [31:0] d, input logic [31:0] m);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        if (!w) rd_q.push_back({m, d & m});
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
    endtask

    task automatic settle;
        repeat (BIT_CYC_I) @(posedge hclk);
        while (tx_q.size() != 0) @(posedge hclk);
    endtask

    // ==========================================
    // output watcher and timeout
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (dph_rd && hreadyout === 1'b1) begin
            e_v = rd_q.pop_front();
            check(hrdata & e_v[63:32], e_v[31:0]);
        end
        if (hreadyout === 1'b1) dph_rd <= hsel & htrans[1] & !hwrite;
        if (got === 1'b1) begin
            check({24'h0, got_ch}, {24'h0, tx_q.pop_front()});
            check({31'h0, frame_ok}, 32'h1);
        end
        if (cyc == LIMIT) begin
            fails++;
            conclude();
        end
    end

    // ==========================================
    // main sequence
    initial begin
        void'($urandom(13));
        {x, y, p, q, r, t} = 48'({$urandom, $urandom});
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        xfer(0, CTRL_ADDR, 32'h0, 32'hFFFF_FFFF);
        xfer(0, LSTAT_ADDR, 32'h20, 32'h2B);
        xfer(0, SHADOW_BASE + SHADOW_SPAN, 32'h0, 32'hFFFF_FFFF);
        xfer(1, IMASK_ADDR, 32'h1, 32'h0);
        // fifo off: overwrite on both paths
        v = $urandom;
        fork
            begin
                peer_u.send(x);
                peer_u.send(y);
            end
            begin
                tx_q.push_back(v[7:0]);
                tx_q.push_back(v[23:16]);
                xfer(1, SHADOW9_ADDR, v, 32'h0);
                xfer(1, SHADOW10_ADDR, v >> 8, 32'h0);
                xfer(0, LSTAT_ADDR, 32'h0, 32'h20);
                xfer(1, SHADOW_BASE, v >> 16, 32'h0);
            end
        join
        settle();
        check({31'h0, irq}, 32'h1);
        xfer(0, LSTAT_ADDR, 32'h3, 32'h3);
        xfer(0, SHADOW9_ADDR, {24'h0, y}, 32'hFFFF_FFFF);
        xfer(0, LSTAT_ADDR, 32'h0, 32'h3);
        xfer(1, ISTAT_ADDR, 32'hF, 32'h0);
        @(posedge hclk);
        check({31'h0, irq}, 32'h0);
        // fifo on: fill transmit past full while two characters arrive
        xfer(1, IMASK_ADDR, 32'h0, 32'h0);
        xfer(1, CTRL_ADDR, 32'h1, 32'h0);
        fork
            begin
                peer_u.send(p);
                peer_u.send(q);
            end
            for (int i = 0; i < 18; i++) begin
                v = $urandom;
                if (i == 0) tx_q.push_back(v[7:0]);
                xfer(1, SHADOW_BASE + 4 * (i % 16), v, 32'h0);
                if (i == 16) xfer(0, ISTAT_ADDR, 32'h0, 32'h8);
                if (i == 16) xfer(0, LSTAT_ADDR, 32'h0, 32'h20);
                if (i == 17) xfer(0, ISTAT_ADDR, 32'h8, 32'h8);
                if (i == 17) xfer(1, CTRL_ADDR, 32'h0, 32'h0);
                if (i == 17) xfer(1, CTRL_ADDR, 32'h1, 32'h0);
            end
        join
        settle();
        check({31'h0, irq}, 32'h0);
        xfer(0, ISTAT_ADDR, 32'h1, 32'h1);
        xfer(1, IMASK_ADDR, 32'h1, 32'h0);
        @(posedge hclk);
        check({31'h0, irq}, 32'h1);
        xfer(1, ISTAT_ADDR, 32'hF, 32'h0);
        xfer(0, SHADOW9_ADDR, {24'h0, p}, 32'hFFFF_FFFF);
        xfer(0, SHADOW_BASE + 32'h3C, {24'h0, q}, 32'hFFFF_FFFF);
        xfer(0, LSTAT_ADDR, 32'h0, 32'h1);
        // infrared mode both ways
        ir <= 1'b1;
        xfer(1, CTRL_ADDR, 32'h3, 32'h0);
        fork
            peer_u.send(r);
            begin
                tx_q.push_back(t);
                xfer(1, SHADOW10_ADDR, {24'h0, t}, 32'h0);
            end
        join
        settle();
        xfer(0, SHADOW10_ADDR, {24'h0, r}, 32'hFFFF_FFFF);
        conclude();
    end
endmodule
